// >>> rtl/beat_capture.v
// holds the last rom beat and flags it for one cycle
`timescale 1ns/1ns
module beat_capture (
  input wire ref_clk,
  input wire rst,
  input wire take,
  input wire [15:0] rom_data,
  output reg beat_valid,
  output reg [15:0] beat_data
);
  always @(posedge ref_clk) begin
    if (rst) begin
      beat_valid <= 1'b0;
      beat_data <= 16'h0000;
    end else begin
      beat_valid <= take;
      if (take) begin
        beat_data <= rom_data;
      end
    end
  end
endmodule

// >>> rtl/burst_rom_wait_control.v
// boot area burst rom access sequencer with its apb wait control register
`timescale 1ns/1ns
`include "burst_rom_wait_defines.vh"

// Function
// - burst beat wait from bits 17:16, 0..3
// - first access wait from bits 10:7
// - bit 6 high ignores external wait
// - wait mask applies with zero first wait
// - reserved bits read back as zero
module burst_rom_wait_control (
  input wire ref_clk,
  input wire rst,
  input wire [11:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire acc_req,
  input wire [1:0] acc_beats,
  output reg acc_busy,
  output wire beat_valid,
  output wire [15:0] beat_data,
  input wire [15:0] rom_data,
  input wire ext_wait_n,
  output reg rom_cs_n,
  output reg rom_rd_n,
  output reg [1:0] rom_beat_idx
);
  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_FIRST = 4'b0010;
  localparam [3:0] ST_BURST = 4'b0100;
  localparam [3:0] ST_END = 4'b1000;

  // first access wait code to cycle count
  function [4:0] first_wait_cycles;
    input [3:0] code;
    begin
      case (code)
        `FW_CODE_0: first_wait_cycles = 5'h00;
        `FW_CODE_1: first_wait_cycles = 5'h01;
        `FW_CODE_2: first_wait_cycles = 5'h02;
        `FW_CODE_3: first_wait_cycles = 5'h03;
        `FW_CODE_4: first_wait_cycles = 5'h04;
        `FW_CODE_5: first_wait_cycles = 5'h05;
        `FW_CODE_6: first_wait_cycles = 5'h06;
        `FW_CODE_7: first_wait_cycles = `FW_CYC_7;
        `FW_CODE_8: first_wait_cycles = `FW_CYC_8;
        `FW_CODE_9: first_wait_cycles = `FW_CYC_9;
        `FW_CODE_A: first_wait_cycles = `FW_CYC_A;
        `FW_CODE_B: first_wait_cycles = `FW_CYC_B;
        `FW_CODE_C: first_wait_cycles = `FW_CYC_C;
        // prohibited codes: take the longest legal wait, the safe side for a slow rom
        default: first_wait_cycles = `FW_CYC_C;
      endcase
    end
  endfunction

  // byte lane merge of a write into a stored word
  function [31:0] lane_merge;
    input [31:0] old_val;
    input [31:0] new_val;
    input [3:0] strb;
    integer i;
    begin
      lane_merge = old_val;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          lane_merge[i*8 +: 8] = new_val[i*8 +: 8];
        end
      end
    end
  endfunction

  // the wait control register decode, used by the write path; the read mux decodes paddr in its own case
  function is_wait_ctrl;
    input [11:0] addr;
    begin
      is_wait_ctrl = (addr == `WAIT_CTRL_ADDR);
    end
  endfunction

  // the rom strobes are low in every state that reads the rom, waits included
  function seq_reads_rom;
    input [3:0] st;
    begin
      seq_reads_rom = (st == ST_FIRST) || (st == ST_BURST);
    end
  endfunction

  // read-only progress word: one-hot state, beats still to come, current beat
  function [31:0] status_word;
    input [3:0] st;
    input [1:0] left;
    input [1:0] idx;
    begin
      status_word = {24'h00_0000, st, left, idx};
    end
  endfunction

  reg [31:0] wait_ctrl_r;
  reg [31:0] wait_ctrl_nxt;
  reg [3:0] state_r;
  reg [3:0] state_nxt;
  reg [1:0] beats_left_r;
  reg [1:0] beats_left_nxt;
  reg [31:0] rd_mux;
  reg addr_hit;
  reg timer_load;
  reg [4:0] timer_val;
  reg take_beat;
  // timing fields held for the burst under way
  reg [1:0] burst_code_r;
  reg wait_ignore_r;
  wire timer_zero;
  wire acc_take;
  wire apb_setup;
  wire apb_write;
  wire [1:0] burst_code;
  wire [3:0] first_code;
  wire wait_ignore;
  wire wait_done;

  assign apb_setup = psel & ~penable;
  assign apb_write = psel & penable & pready & pwrite;
  assign burst_code = wait_ctrl_r[`BURST_WAIT_HI:`BURST_WAIT_LO];
  assign first_code = wait_ctrl_r[`FIRST_WAIT_HI:`FIRST_WAIT_LO];
  assign wait_ignore = wait_ctrl_r[`EXT_WAIT_IGNORE_BIT];
  // a request counts only while the sequencer is idle; one that arrives during
  // a burst is dropped without any sign, so software must watch acc_busy
  assign acc_take = (state_r == ST_IDLE) & acc_req;

  // read mux and decode, done in the setup cycle so prdata is a flop
  always @* begin
    rd_mux = 32'h0000_0000;
    addr_hit = 1'b1;
    case (paddr)
      `WAIT_CTRL_ADDR: rd_mux = wait_ctrl_r & `WAIT_CTRL_MASK;
      `ACC_STATUS_ADDR: rd_mux = status_word(state_r, beats_left_r, rom_beat_idx);
      default: addr_hit = 1'b0;
    endcase
  end

  // reserved bits never store, so a careless write cannot leak into them
  always @* begin
    wait_ctrl_nxt = wait_ctrl_r;
    if (apb_write && !pslverr && is_wait_ctrl(paddr)) begin
      wait_ctrl_nxt = lane_merge(wait_ctrl_r, pwdata, pstrb) & `WAIT_CTRL_MASK;
    end
  end

  // one setup cycle and one access cycle for every transfer
  always @(posedge ref_clk) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= apb_setup;
      if (apb_setup) begin
        pslverr <= ~addr_hit;
        prdata <= pwrite ? 32'h0000_0000 : rd_mux;
      end else begin
        pslverr <= 1'b0;
        prdata <= 32'h0000_0000;
      end
    end
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      wait_ctrl_r <= `WAIT_CTRL_RESET;
    end else begin
      wait_ctrl_r <= wait_ctrl_nxt;
    end
  end

  // timing fields are frozen when a burst is taken, so a register write that
  // lands mid-burst cannot retime beats already under way
  always @(posedge ref_clk) begin
    if (rst) begin
      burst_code_r <= 2'b00;
      wait_ignore_r <= 1'b0;
    end else if (acc_take) begin
      burst_code_r <= burst_code;
      wait_ignore_r <= wait_ignore;
    end
  end

  // a wait phase ends once its count is spent and the rom is not holding off;
  // the external input is looked at even when the count is zero
  assign wait_done = timer_zero & (wait_ignore_r | ext_wait_n);

  always @* begin
    state_nxt = state_r;
    beats_left_nxt = beats_left_r;
    timer_load = 1'b0;
    timer_val = 5'h00;
    take_beat = 1'b0;
    case (state_r)
      ST_IDLE: begin
        if (acc_req) begin
          state_nxt = ST_FIRST;
          beats_left_nxt = acc_beats;
          timer_load = 1'b1;
          timer_val = first_wait_cycles(first_code);
        end
      end
      ST_FIRST: begin
        if (wait_done) begin
          take_beat = 1'b1;
          if (beats_left_r == 2'b00) begin
            state_nxt = ST_END;
          end else begin
            state_nxt = ST_BURST;
            beats_left_nxt = beats_left_r - 2'b01;
            timer_load = 1'b1;
            timer_val = {3'b000, burst_code_r};
          end
        end
      end
      ST_BURST: begin
        if (wait_done) begin
          take_beat = 1'b1;
          if (beats_left_r == 2'b00) begin
            state_nxt = ST_END;
          end else begin
            beats_left_nxt = beats_left_r - 2'b01;
            timer_load = 1'b1;
            timer_val = {3'b000, burst_code_r};
          end
        end
      end
      // one closing cycle with the strobes high before the sequencer goes idle
      ST_END: begin
        state_nxt = ST_IDLE;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      state_r <= ST_IDLE;
      beats_left_r <= 2'b00;
      acc_busy <= 1'b0;
    end else begin
      state_r <= state_nxt;
      beats_left_r <= beats_left_nxt;
      acc_busy <= (state_nxt != ST_IDLE);
    end
  end

  // strobes follow the next state, so they move on the same edge as the
  // sequencer and stay low through every wait phase of the burst
  always @(posedge ref_clk) begin
    if (rst) begin
      rom_cs_n <= 1'b1;
      rom_rd_n <= 1'b1;
    end else begin
      rom_cs_n <= ~seq_reads_rom(state_nxt);
      rom_rd_n <= ~seq_reads_rom(state_nxt);
    end
  end

  // the beat index restarts in idle and steps once for every beat taken
  always @(posedge ref_clk) begin
    if (rst) begin
      rom_beat_idx <= 2'b00;
    end else if (state_r == ST_IDLE) begin
      rom_beat_idx <= 2'b00;
    end else if (take_beat) begin
      rom_beat_idx <= rom_beat_idx + 2'b01;
    end
  end

  wait_timer u_timer (
    .ref_clk(ref_clk),
    .rst(rst),
    .load(timer_load),
    .load_val(timer_val),
    .zero(timer_zero)
  );

  beat_capture u_capture (
    .ref_clk(ref_clk),
    .rst(rst),
    .take(take_beat),
    .rom_data(rom_data),
    .beat_valid(beat_valid),
    .beat_data(beat_data)
  );
endmodule

// >>> rtl/burst_rom_wait_defines.vh
// constants for the boot area burst rom wait controller
`ifndef BURST_ROM_WAIT_DEFINES_VH
`define BURST_ROM_WAIT_DEFINES_VH

// register byte addresses
`define WAIT_CTRL_ADDR 12'h000
`define ACC_STATUS_ADDR 12'h004

// field positions in the wait control register
`define BURST_WAIT_HI 17
`define BURST_WAIT_LO 16
`define FIRST_WAIT_HI 10
`define FIRST_WAIT_LO 7
`define EXT_WAIT_IGNORE_BIT 6

// writable bits and the value after reset
`define WAIT_CTRL_MASK 32'h0003_07c0
`define WAIT_CTRL_RESET 32'h0000_0500

// first access wait code to cycles
`define FW_CODE_0 4'h0
`define FW_CODE_1 4'h1
`define FW_CODE_2 4'h2
`define FW_CODE_3 4'h3
`define FW_CODE_4 4'h4
`define FW_CODE_5 4'h5
`define FW_CODE_6 4'h6
`define FW_CODE_7 4'h7
`define FW_CODE_8 4'h8
`define FW_CODE_9 4'h9
`define FW_CODE_A 4'ha
`define FW_CODE_B 4'hb
`define FW_CODE_C 4'hc
`define FW_CYC_7 5'h08
`define FW_CYC_8 5'h0a
`define FW_CYC_9 5'h0c
`define FW_CYC_A 5'h0e
`define FW_CYC_B 5'h12
`define FW_CYC_C 5'h18

`define TIMER_W 5
`define ROM_DATA_W 16

`endif

// >>> rtl/wait_timer.v
// down counter that times the inserted wait cycles
`timescale 1ns/1ns
module wait_timer (
  input wire ref_clk,
  input wire rst,
  input wire load,
  input wire [4:0] load_val,
  output wire zero
);
  reg [4:0] count_r;
  reg [4:0] count_nxt;

  always @* begin
    count_nxt = count_r;
    if (load) begin
      count_nxt = load_val;
    end else if (count_r != 5'h00) begin
      count_nxt = count_r - 5'h01;
    end
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      count_r <= 5'h00;
    end else begin
      count_r <= count_nxt;
    end
  end

  assign zero = (count_r == 5'h00);
endmodule

// >>> verification/burst_rom_wait_chk.sv
// port-level assertions for the burst rom wait controller
`timescale 1ns/1ns
module burst_rom_wait_chk (
  input wire ref_clk,
  input wire rst,
  input wire [11:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire acc_req,
  input wire acc_busy,
  input wire beat_valid,
  input wire rom_cs_n,
  input wire rom_rd_n
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_apb_answer: assert property (psel && !penable |=> pready) else $error("no answer");
  a_pready_once: assert property (pready |=> !pready) else $error("pready held");
  a_resv_zero: assert property (pready && !pwrite && paddr == 12'h000 |->
    (prdata & 32'hfffc_f83f) == 32'h0000_0000) else $error("reserved bits set");
  a_unmapped_err: assert property (pready |-> pslverr == (paddr != 12'h000 &&
    paddr != 12'h004)) else $error("pslverr wrong");
  a_beat_in_sel: assert property (beat_valid |-> !$past(rom_cs_n))
    else $error("beat outside select");
  a_strobe_pair: assert property (rom_cs_n == rom_rd_n) else $error("strobes differ");
  a_sel_busy: assert property (!rom_cs_n |-> acc_busy) else $error("select while idle");
  a_first_gap: assert property ($rose(acc_busy) |-> !beat_valid && $past(acc_req))
    else $error("early beat");
  c_beat: cover property (beat_valid ##1 !beat_valid [*1] ##1 beat_valid);
  c_err: cover property (pready && pslverr);
  c_stall: cover property (!rom_cs_n && acc_busy ##1 beat_valid);
endmodule
bind burst_rom_wait_control burst_rom_wait_chk u_chk (.ref_clk, .rst, .paddr, .psel, .penable,
  .pwrite, .prdata, .pready, .pslverr, .acc_req, .acc_busy, .beat_valid, .rom_cs_n, .rom_rd_n);

// >>> verification/rom_model.sv
// burst rom model whose wait request the bench steers
`timescale 1ns/1ns
module rom_model (
  input wire ref_clk,
  input wire rom_cs_n,
  input wire rom_rd_n,
  input wire [1:0] rom_beat_idx,
  input wire stall,
  output wire [15:0] rom_data,
  output wire ext_wait_n
);
  logic [15:0] last_r = 16'h0000;
  wire sel = !rom_cs_n && !rom_rd_n;
  // a released bus shows the inverse of its last value so stale data never matches
  assign rom_data = sel ? {14'h1690, rom_beat_idx} : ~last_r;
  assign ext_wait_n = !(stall && !rom_cs_n);
  always @(posedge ref_clk) if (sel) last_r <= rom_data;
endmodule

// >>> verification/test_burst_rom_wait_control.sv
// self-checking bench for the burst rom wait controller
`timescale 1ns/1ns
module test_burst_rom_wait_control;
  logic ref_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, acc_req = 0, stall = 0, er;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd, r;
  logic [3:0] pstrb = 4'hf;
  logic [1:0] acc_beats = 2'h0, rom_beat_idx;
  logic pready, pslverr, acc_busy, beat_valid, ext_wait_n, rom_cs_n, rom_rd_n;
  logic [15:0] beat_data, rom_data;
  integer n_errors = 0, cmp_count = 0, seed = 32'h6005, i;
  burst_rom_wait_control i_dut (.ref_clk, .rst, .paddr, .psel, .penable, .pwrite, .pwdata,
    .pstrb, .prdata, .pready, .pslverr, .acc_req, .acc_beats, .acc_busy, .beat_valid,
    .beat_data, .rom_data, .ext_wait_n, .rom_cs_n, .rom_rd_n, .rom_beat_idx);
  rom_model i_rom (.ref_clk, .rom_cs_n, .rom_rd_n, .rom_beat_idx, .stall, .rom_data,
    .ext_wait_n);
  initial forever #5 ref_clk = ~ref_clk;
  function integer fw(input logic [3:0] c);
    case (c)
      7: fw = 8; 8: fw = 10; 9: fw = 12; 10: fw = 14; 11: fw = 18; 12: fw = 24;
      default: fw = c;
    endcase
  endfunction
  task chk_val(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task chk_cyc(input string n, input integer e, input integer g);
    cmp_count++;
    if (g != e) begin
      n_errors++;
      $display("[ERR] %s expected %0d seen %0d", n, e, g);
    end
  endtask
  task stop_test;
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    integer t;
    begin
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1;
      t = 0;
      do begin
        @(posedge ref_clk);
        t++;
      end while (pready !== 1'b1 && t < 50);
      rd = prdata;
      er = pslverr;
      if (pready !== 1'b1) n_errors++;
      psel <= 0;
      penable <= 0;
      @(posedge ref_clk);
    end
  endtask
  task burst(input logic [3:0] f, input logic [1:0] b, input logic ig, input logic [1:0] nb,
             input logic st);
    integer k, t, p;
    begin
      apb(1, 12'h000, {14'h0000, b, 5'h00, f, ig, 6'h00});
      acc_req <= 1;
      acc_beats <= nb;
      stall <= st;
      @(posedge ref_clk);
      acc_req <= 0;
      t = 0;
      p = 0;
      for (k = 0; k <= nb; k++) begin
        do begin
          @(posedge ref_clk);
          t++;
          if (t == 3) stall <= 0;
        end while (beat_valid !== 1'b1 && t < 300);
        if (beat_valid !== 1'b1) n_errors++;
        if (k == 0 && st && !ig) chk_cyc("wait_ext", fw(f) > 3 ? fw(f) + 2 : 5, t);
        else chk_cyc("gap", k ? b + 1 : fw(f) + 2, t - p);
        chk_val("beat", 32'h0000_5a40 + k, beat_data);
        p = t;
      end
      @(posedge ref_clk);
      chk_val("busy", 0, acc_busy);
      $display("burst f=%0d b=%0d m=%0d done", f, b, ig);
    end
  endtask
  initial begin
    repeat (2) @(posedge ref_clk);
    rst <= 0;
    @(posedge ref_clk);
    apb(0, 12'h000, 32'h0000_0000);
    chk_val("reset_val", 32'h0000_0500, rd);
    apb(0, 12'h010, 32'h0000_0000);
    chk_val("unmapped", 1, er);
    chk_val("unmapped_data", 0, rd);
    apb(0, 12'h004, 32'h0000_0000);
    chk_val("status_idle", 32'h0000_0010, rd);
    apb(1, 12'h000, 32'h0003_0640);
    apb(0, 12'h000, 32'h0000_0000);
    chk_val("readback", 32'h0003_0640, rd);
    apb(1, 12'h010, 32'h0000_0000);
    apb(0, 12'h000, 32'h0000_0000);
    chk_val("unmapped_wr", 32'h0003_0640, rd);
    $display("register tests done");
    for (i = 0; i < 13; i++) burst(i[3:0], i[1:0], 1, 3, 0);
    burst(4'h0, 2'h0, 1, 1, 1);
    burst(4'h0, 2'h2, 0, 2, 1);
    burst(4'h1, 2'h1, 0, 0, 1);
    for (i = 0; i < 10; i++) begin
      r = $random(seed);
      burst(r[7:4] % 4'hd, r[1:0], r[2], r[9:8], r[2]);
    end
    stop_test;
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_errors++;
    stop_test;
  end
endmodule
